// *** pts_pkg.sv ***
// package for the ptp time sync unit: register map, fields, resets, types
// assumes a 32-bit plain register port and one 125 MHz clock
// Behaviour
// [RULE1] receive match bits 15:0 hold ethertype, reset 0x88F7, network order
// [RULE2] receive match bits 23:16 hold version-1 control value, reset zero
// [RULE3] receive match bits 31:24 hold version-2 message id, reset zero
// [RULE4] udp match bits 15:0 hold port, reset 0x319, upper bits read zero
// [RULE5] transmit valid flag, control bit 0, sets when a stamp is latched
// [RULE6] reading the transmit stamp high word clears the transmit valid flag
// [RULE7] transmit stamps taken only while control bit 4 is one
// [RULE8] transmit stamp readable as low and high words, reset zero
// [RULE9] system time is 64 bits in two writable words, reset zero
// [RULE10] increment amount bits 23:0, increment period bits 31:24, reset zero
// [RULE11] adjustment: 32-bit low, 31-bit high magnitude, bit 31 sign subtracts
// [RULE12] receive valid flag sets on latch, clears on read of receive high word; the all-packets type latches without setting it
// [RULE13] 3-bit receive type selects which received packets get stamped
// [RULE14] add increment once per increment period cycles; period zero holds time
// [RULE15] signed adjustment applied once after the high adjustment word is written
package pts_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam logic [ADDR_W-1:0] OFS_TIME_LO = 16'hB600;
  localparam logic [ADDR_W-1:0] OFS_TIME_HI = 16'hB604;
  localparam logic [ADDR_W-1:0] OFS_INC = 16'hB608;
  localparam logic [ADDR_W-1:0] OFS_ADJ_LO = 16'hB60C;
  localparam logic [ADDR_W-1:0] OFS_ADJ_HI = 16'hB610;
  localparam logic [ADDR_W-1:0] OFS_TX_CTL = 16'hB614;
  localparam logic [ADDR_W-1:0] OFS_TX_LO = 16'hB618;
  localparam logic [ADDR_W-1:0] OFS_TX_HI = 16'hB61C;
  localparam logic [ADDR_W-1:0] OFS_RX_CTL = 16'hB620;
  localparam logic [ADDR_W-1:0] OFS_RX_LO = 16'hB624;
  localparam logic [ADDR_W-1:0] OFS_RX_HI = 16'hB628;
  localparam logic [ADDR_W-1:0] OFS_RX_MATCH = 16'hB634;
  localparam logic [ADDR_W-1:0] OFS_UDP = 16'hB638;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 16'hB640;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 16'hB644;

  localparam logic [15:0] RST_ETHERTYPE = 16'h88F7;
  localparam logic [15:0] RST_UDP_PORT = 16'h0319;
  localparam int unsigned BIT_VALID = 0;
  localparam int unsigned BIT_EN = 4;
  localparam int unsigned RX_TYPE_LSB = 1;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_TX = 0;
  localparam int unsigned IRQ_RX = 1;

  typedef enum logic [2:0] {
    RXT_L2_V2 = 3'h0,
    RXT_L4_V1 = 3'h1,
    RXT_V2_ALL = 3'h2,
    RXT_ALL = 3'h4,
    RXT_V2_EVENT = 3'h5
  } pts_rx_type_t;

  // packet classification from the controller's receive parser
  typedef struct packed {
    logic stamp;
    logic is_l2;
    logic is_l4;
    logic is_v1;
    logic is_v2;
    logic [15:0] ethertype;
    logic [15:0] udp_port;
    logic [7:0] v1_control;
    logic [7:0] v2_msg_id;
  } pts_rx_pkt_t;

  typedef struct packed {
    logic [31:0] amount_hi;
    logic [31:0] amount_lo;
  } pts_word_pair_t;
endpackage : pts_pkg

// *** pts_time_sync.sv ***
// ptp time sync unit: system time, adjust, transmit and receive stamp capture
// assumes packet path strobes are one-cycle pulses synchronous to clk_sys_i
`timescale 1ns/100ps
module pts_time_sync
  import pts_pkg::*;
(
  input wire logic clk_sys_i, // 125 MHz system clock
  input wire logic rstn_i, // async reset, active low
  input wire logic [ADDR_W-1:0] addr_i, // register byte address
  input wire logic [31:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [31:0] rdata_o, // read data, cycle after rd_i
  input wire logic tx_stamp_i, // transmit sof event pulse
  input wire pts_rx_pkt_t rx_pkt_i, // receive event and its classification
  output logic [63:0] time_o, // running system time
  output logic rx_match_o, // pulse: received packet was stamped
  output logic irq_o // level interrupt
);
  logic [31:0] time_lo_q, time_hi_q;
  logic [23:0] inc_amount_q;
  logic [7:0] inc_period_q, period_cnt_q;
  logic [31:0] adj_lo_q;
  logic [30:0] adj_hi_q;
  logic adj_sign_q, adj_go_q;
  logic tx_en_q, tx_valid_q;
  pts_word_pair_t tx_stamp_q, rx_stamp_q;
  logic rx_en_q, rx_valid_q;
  logic [2:0] rx_type_q;
  logic [15:0] ethertype_q, udp_port_q;
  logic [7:0] v1_ctl_q, v2_id_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_mask_q;
  logic tick, rx_hit, tx_take, rx_take;
  logic [63:0] now;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
    return a == o;
  endfunction : hit

  assign now = {time_hi_q, time_lo_q};
  assign time_o = now;

  // increment period counter
  assign tick = (inc_period_q != 8'h00) && (period_cnt_q == inc_period_q - 8'h01); // RULE14
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      period_cnt_q <= 8'h00;
    end else if (inc_period_q == 8'h00 || tick) begin
      period_cnt_q <= 8'h00;
    end else begin
      period_cnt_q <= period_cnt_q + 8'h01;
    end
  end

  // system time: software write wins; otherwise the signed adjust and the increment both apply in the same cycle
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    logic [63:0] nxt;
    if (!rstn_i) begin
      time_lo_q <= 32'h0000_0000; // RULE9
      time_hi_q <= 32'h0000_0000;
    end else begin
      nxt = now;
      if (adj_go_q) begin
        if (adj_sign_q) begin
          nxt = nxt - {1'b0, adj_hi_q, adj_lo_q}; // RULE15 RULE11
        end else begin
          nxt = nxt + {1'b0, adj_hi_q, adj_lo_q};
        end
      end
      if (tick) begin
        nxt = nxt + {40'h00_0000_0000, inc_amount_q}; // RULE14
      end
      time_lo_q <= (wr_i && hit(addr_i, OFS_TIME_LO)) ? wdata_i : nxt[31:0]; // RULE9
      time_hi_q <= (wr_i && hit(addr_i, OFS_TIME_HI)) ? wdata_i : nxt[63:32];
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      inc_amount_q <= 24'h00_0000;
      inc_period_q <= 8'h00;
      adj_lo_q <= 32'h0000_0000;
      adj_hi_q <= 31'h0000_0000;
      adj_sign_q <= 1'b0;
      adj_go_q <= 1'b0;
      tx_en_q <= 1'b0;
      rx_en_q <= 1'b0;
      rx_type_q <= 3'h0;
      ethertype_q <= RST_ETHERTYPE;
      v1_ctl_q <= 8'h00;
      v2_id_q <= 8'h00;
      udp_port_q <= RST_UDP_PORT;
      irq_mask_q <= '0;
    end else begin
      adj_go_q <= wr_i && hit(addr_i, OFS_ADJ_HI); // RULE15
      if (wr_i) begin
        case (addr_i)
          OFS_INC: begin
            inc_amount_q <= wdata_i[23:0]; // RULE10
            inc_period_q <= wdata_i[31:24];
          end
          OFS_ADJ_LO: adj_lo_q <= wdata_i; // RULE11
          OFS_ADJ_HI: begin
            adj_hi_q <= wdata_i[30:0];
            adj_sign_q <= wdata_i[31];
          end
          OFS_TX_CTL: tx_en_q <= wdata_i[BIT_EN]; // RULE7
          OFS_RX_CTL: begin
            rx_en_q <= wdata_i[BIT_EN];
            rx_type_q <= wdata_i[RX_TYPE_LSB +: 3]; // RULE13
          end
          OFS_RX_MATCH: begin
            ethertype_q <= wdata_i[15:0]; // RULE1
            v1_ctl_q <= wdata_i[23:16]; // RULE2
            v2_id_q <= wdata_i[31:24]; // RULE3
          end
          OFS_UDP: udp_port_q <= wdata_i[15:0]; // RULE4
          OFS_IRQ_MASK: irq_mask_q <= wdata_i[IRQ_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // receive match: match values compared as stored, both in network order
  always_comb begin
    logic l2_ok, l4_ok, v1_ok, v2_ok;
    l2_ok = rx_pkt_i.is_l2 && (rx_pkt_i.ethertype == ethertype_q); // RULE1
    l4_ok = rx_pkt_i.is_l4 && (rx_pkt_i.udp_port == udp_port_q); // RULE4
    v1_ok = rx_pkt_i.is_v1 && (rx_pkt_i.v1_control == v1_ctl_q); // RULE2
    v2_ok = rx_pkt_i.is_v2 && (rx_pkt_i.v2_msg_id == v2_id_q); // RULE3
    case (rx_type_q)
      RXT_L2_V2: rx_hit = l2_ok && v2_ok; // RULE13
      RXT_L4_V1: rx_hit = l4_ok && v1_ok;
      RXT_V2_ALL: rx_hit = (l2_ok || l4_ok) && v2_ok;
      RXT_ALL: rx_hit = 1'b1;
      RXT_V2_EVENT: rx_hit = rx_pkt_i.is_v2 && !rx_pkt_i.v2_msg_id[3];
      default: rx_hit = 1'b0;
    endcase
  end

  // stamps lock while valid; the all-packets mode never locks
  assign tx_take = tx_stamp_i && tx_en_q && !tx_valid_q; // RULE7
  assign rx_take = rx_pkt_i.stamp && rx_en_q && rx_hit
                   && (!rx_valid_q || rx_type_q == RXT_ALL);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_stamp_q <= '0; // RULE8
      tx_valid_q <= 1'b0;
    end else begin
      if (tx_take) begin
        tx_stamp_q <= {time_hi_q, time_lo_q}; // RULE8
      end
      // set wins over the clearing read
      if (tx_take) begin
        tx_valid_q <= 1'b1; // RULE5
      end else if (rd_i && hit(addr_i, OFS_TX_HI)) begin
        tx_valid_q <= 1'b0; // RULE6
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_stamp_q <= '0;
      rx_valid_q <= 1'b0;
      rx_match_o <= 1'b0;
    end else begin
      rx_match_o <= rx_take;
      if (rx_take) begin
        rx_stamp_q <= {time_hi_q, time_lo_q};
      end
      if (rx_take && rx_type_q != RXT_ALL) begin
        rx_valid_q <= 1'b1; // RULE12
      end else if (rd_i && hit(addr_i, OFS_RX_HI)) begin
        rx_valid_q <= 1'b0; // RULE12
      end
    end
  end

  // interrupt status: write one to clear, capture wins
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    logic [IRQ_W-1:0] ev;
    if (!rstn_i) begin
      irq_stat_q <= '0;
    end else begin
      ev = '0;
      ev[IRQ_TX] = tx_take;
      ev[IRQ_RX] = rx_take;
      if (wr_i && hit(addr_i, OFS_IRQ_STAT)) begin
        irq_stat_q <= (irq_stat_q & ~wdata_i[IRQ_W-1:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // read port, unmapped reads return zero
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        OFS_TIME_LO: rdata_o <= time_lo_q;
        OFS_TIME_HI: rdata_o <= time_hi_q;
        OFS_INC: rdata_o <= {inc_period_q, inc_amount_q}; // RULE10
        OFS_ADJ_LO: rdata_o <= adj_lo_q;
        OFS_ADJ_HI: rdata_o <= {adj_sign_q, adj_hi_q};
        OFS_TX_CTL: rdata_o <= {27'h000_0000, tx_en_q, 3'h0, tx_valid_q}; // RULE5
        OFS_TX_LO: rdata_o <= tx_stamp_q.amount_lo;
        OFS_TX_HI: rdata_o <= tx_stamp_q.amount_hi;
        OFS_RX_CTL: rdata_o <= {27'h000_0000, rx_en_q, rx_type_q, rx_valid_q};
        OFS_RX_LO: rdata_o <= rx_stamp_q.amount_lo;
        OFS_RX_HI: rdata_o <= rx_stamp_q.amount_hi;
        OFS_RX_MATCH: rdata_o <= {v2_id_q, v1_ctl_q, ethertype_q};
        OFS_UDP: rdata_o <= {16'h0000, udp_port_q}; // RULE4
        OFS_IRQ_STAT: rdata_o <= {30'h0000_0000, irq_stat_q};
        OFS_IRQ_MASK: rdata_o <= {30'h0000_0000, irq_mask_q};
        default: rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
endmodule : pts_time_sync

// *** pts_time_sync_sva.sv ***
// port assertions for the ptp time sync unit
// assumes one clock domain and the plain register port
`timescale 1ns/100ps
module pts_time_sync_sva
  import pts_pkg::*;
(
  input wire logic clk_sys_i, // clock
  input wire logic rstn_i, // reset, active low
  input wire logic [ADDR_W-1:0] addr_i, // address
  input wire logic [31:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [31:0] rdata_o, // read data
  input wire logic tx_stamp_i, // transmit event
  input wire pts_rx_pkt_t rx_pkt_i, // receive event
  input wire logic [63:0] time_o, // system time
  input wire logic rx_match_o, // receive stamp pulse
  input wire logic irq_o // interrupt
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  a_txctl_rsvd_zero: assert property (rd_i && addr_i == OFS_TX_CTL |=>
    (rdata_o & 32'hFFFFFFEE) == 32'h0) else $error("transmit control reserved bits set");
  a_udp_port_readback: assert property ((wr_i && addr_i == OFS_UDP) ##1 !wr_i
    ##1 (rd_i && addr_i == OFS_UDP) |=> rdata_o == ($past(wdata_i, 3) & 32'h0000FFFF))
    else $error("udp port readback wrong");
  a_tx_valid_clear: assert property ((rd_i && addr_i == OFS_TX_HI && !tx_stamp_i)
    ##1 !tx_stamp_i ##1 (rd_i && addr_i == OFS_TX_CTL) |=> !rdata_o[BIT_VALID])
    else $error("transmit valid not cleared by high read");
  a_time_low_write: assert property (wr_i && addr_i == OFS_TIME_LO |=>
    time_o[31:0] == $past(wdata_i)) else $error("time low write lost");
  a_time_high_read: assert property (rd_i && addr_i == OFS_TIME_HI |=>
    rdata_o == $past(time_o[63:32])) else $error("time high read wrong");
  a_rx_match_cause: assert property (rx_match_o |-> $past(rx_pkt_i.stamp))
    else $error("receive match without event");
  a_irq_rise_cause: assert property ($rose(irq_o) |->
    $past(tx_stamp_i || rx_pkt_i.stamp || wr_i)) else $error("interrupt without cause");
  c_rx_match: cover property (rx_match_o);
  c_irq_rise: cover property ($rose(irq_o));
  c_tx_high_read: cover property (rd_i && addr_i == OFS_TX_HI);
endmodule : pts_time_sync_sva

bind pts_time_sync pts_time_sync_sva i_sva (.clk_sys_i, .rstn_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .tx_stamp_i, .rx_pkt_i, .time_o, .rx_match_o, .irq_o);

// *** pts_pkt_model.sv ***
// model of the controller packet paths: one-cycle stamp events
// assumes the caller waits for each task to return
`timescale 1ns/100ps
module pts_pkt_model
  import pts_pkg::*;
(
  input wire logic clk_sys_i, // system clock
  output logic tx_stamp_o, // transmit event pulse
  output pts_rx_pkt_t rx_pkt_o // receive event and class
);
  initial begin
    tx_stamp_o = 1'b0;
    rx_pkt_o = '0;
  end
  task automatic send_tx();
    @(posedge clk_sys_i) tx_stamp_o <= 1'b1;
    @(posedge clk_sys_i) tx_stamp_o <= 1'b0;
  endtask : send_tx
  task automatic send_rx(input pts_rx_pkt_t p);
    pts_rx_pkt_t q;
    q = ~p;
    q.stamp = 1'b0;
    @(posedge clk_sys_i) rx_pkt_o <= p;
    // class fields turn to garbage after the pulse, so late sampling shows
    @(posedge clk_sys_i) rx_pkt_o <= q;
  endtask : send_rx
endmodule : pts_pkt_model

// *** testbench.sv ***
// register-level tests of the ptp time sync unit
// assumes the partner model drives the packet path events
`timescale 1ns/100ps
module testbench;
  import pts_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o, t0, t1;
  logic tx_stamp;
  pts_rx_pkt_t rx_pkt, pk [2];
  logic [63:0] time_o;
  logic rx_match_o, irq_o, hit;
  int n_mismatch = 0;
  int checked = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  pts_pkt_model i_model (.clk_sys_i(clk_sys_i), .tx_stamp_o(tx_stamp), .rx_pkt_o(rx_pkt));
  pts_time_sync i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_stamp_i(tx_stamp),
    .rx_pkt_i(rx_pkt), .time_o(time_o), .rx_match_o(rx_match_o), .irq_o(irq_o));
  task automatic stop_test();
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys_i) begin addr_i <= a; wdata_i <= d; wr_i <= 1'b1; end
    @(posedge clk_sys_i) wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_sys_i) begin addr_i <= a; rd_i <= 1'b1; end
    @(posedge clk_sys_i) rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task automatic rc(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    cmp($sformatf("reg %h", a), e, d);
  endtask : rc
  initial begin
    #40000 n_mismatch++;
    stop_test();
  end
  initial begin
    pk[0] = {5'b10110, 16'h0, 16'hFFFF, 8'h0, 8'h0};
    pk[1] = {5'b11001, 16'h88F7, 16'h0, 8'h0, 8'h02};
    repeat (12) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    for (int a = 16'hB600; a <= 16'hB650; a += 4)
      rc(a[15:0], a == 16'hB634 ? 32'h000088F7 : a == 16'hB638 ? 32'h00000319 : 32'h0);
    wr(OFS_RX_MATCH, 32'hFFFFFFFF);
    rc(OFS_RX_MATCH, 32'hFFFFFFFF);
    wr(OFS_UDP, 32'hFFFFFFFF);
    rc(OFS_UDP, 32'h0000FFFF);
    wr(OFS_TX_LO, 32'hFFFFFFFF);
    rc(OFS_TX_LO, 32'h0);
    wr(OFS_INC, 32'h00FFFFFF);
    rc(OFS_INC, 32'h00FFFFFF);
    wr(OFS_TIME_LO, 32'h0000000A);
    wr(OFS_TIME_HI, 32'h00000001);
    wr(OFS_ADJ_LO, 32'h0000001E);
    wr(OFS_ADJ_HI, 32'h80000000);
    rc(OFS_ADJ_HI, 32'h80000000);
    rc(OFS_TIME_HI, 32'h0);
    rc(OFS_TIME_LO, 32'hFFFFFFEC);
    wr(OFS_ADJ_HI, 32'h0);
    rc(OFS_TIME_HI, 32'h1);
    rc(OFS_TIME_LO, 32'h0000000A);
    // high magnitude field carries into the upper time word
    wr(OFS_ADJ_HI, 32'h00000001);
    rc(OFS_TIME_HI, 32'h2);
    rc(OFS_TIME_LO, 32'h00000028);
    for (int p = 0; p < 2; p++) begin
      // read spacing of 8 cycles spans two whole periods of 4
      // second pass keeps a nonzero amount so a zero period must really hold
      wr(OFS_INC, p ? 32'h00000005 : 32'h04000005);
      rd(OFS_TIME_LO, t0);
      repeat (6) @(posedge clk_sys_i);
      rd(OFS_TIME_LO, t1);
      cmp("time step", p ? 32'h0 : 32'hA, t1 - t0);
    end
    wr(OFS_TIME_LO, 32'hABCD0123);
    wr(OFS_TIME_HI, 32'h00000042);
    #1 cmp("time high", 32'h00000042, time_o[63:32]);
    cmp("time low", 32'hABCD0123, time_o[31:0]);
    wr(OFS_TX_CTL, 32'h0);
    i_model.send_tx();
    rc(OFS_TX_CTL, 32'h0);
    wr(OFS_TX_CTL, 32'h10);
    i_model.send_tx();
    rc(OFS_TX_CTL, 32'h11);
    wr(OFS_TIME_LO, 32'h0);
    i_model.send_tx();
    rc(OFS_TX_LO, 32'hABCD0123);
    rc(OFS_TX_HI, 32'h42);
    rc(OFS_TX_CTL, 32'h10);
    rc(OFS_IRQ_STAT, 32'h1);
    wr(OFS_IRQ_MASK, 32'h3);
    #1 cmp("irq", 32'h1, {31'h0, irq_o});
    wr(OFS_IRQ_STAT, 32'h1);
    #1 cmp("irq", 32'h0, {31'h0, irq_o});
    wr(OFS_RX_CTL, 32'h00000008);
    i_model.send_rx(pk[1]);
    #1 cmp("rx disabled", 32'h0, {31'h0, rx_match_o});
    wr(OFS_RX_MATCH, 32'h020088F7);
    for (int t = 0; t < 6; t++) begin
      wr(OFS_RX_CTL, 32'h10 | (t << 1));
      for (int j = 0; j < 2; j++) begin
        hit = j ? (t == 0 || t == 2 || t == 4 || t == 5) : (t == 1 || t == 4);
        i_model.send_rx(pk[j]);
        #1 cmp("rx match", {31'h0, hit}, {31'h0, rx_match_o});
        rc(OFS_RX_CTL, 32'h10 | (t << 1) | (hit && t != 4));
        rc(OFS_IRQ_STAT, {30'h0, hit, 1'b0});
        wr(OFS_IRQ_STAT, 32'h2);
        if (hit && t != 4) rc(OFS_RX_HI, 32'h42);
      end
    end
    // reset in mid-run must bring back the time high, udp, match and transmit control reset values
    @(posedge clk_sys_i) rstn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    #1 cmp("time reset", 32'h0, time_o[63:32]);
    rc(OFS_UDP, 32'h00000319);
    rc(OFS_RX_MATCH, 32'h000088F7);
    rc(OFS_TX_CTL, 32'h0);
    stop_test();
  end
endmodule : testbench
